// File: lit_consts.svh
// Constants for the transmit and mode control block
`ifndef LIT_CONSTS_SVH
`define LIT_CONSTS_SVH
`define REF_PERIOD_NS 10
`define PW_PCM30_NS 244
`define PW_PART68_NS 324
`define PW_DSX1_NS 350
`define PW_PCM30_CYC 8'(`PW_PCM30_NS / `REF_PERIOD_NS)
`define PW_PART68_CYC 8'(`PW_PART68_NS / `REF_PERIOD_NS)
`define PW_DSX1_CYC 8'(`PW_DSX1_NS / `REF_PERIOD_NS)
`define TX_LOSS_NS 2000
`define TX_LOSS_CYC 9'(`TX_LOSS_NS / `REF_PERIOD_NS)
`define SETTLE_BITS 8'h16
`define REMOTE_LOOPBACK_SETTLE_BITS 8'h58
`define LEN_PCM30 3'h0
`define LEN_RESERVED 3'h1
`define LEN_PART68 3'h2
`define LEN_DSX_FIRST 3'h3
`define PIN_W 13
`define PIN_MODE_LOW 12
`define PIN_MODE_HIGH 11
`define PIN_TX_CLOCK 10
`define PIN_TX_POS_RAIL 9
`define PIN_TX_NEG_RAIL 8
`define PIN_MON_A 7
`define PIN_MON_B 6
`define CP_LINE_LENGTH_SEL_0 0
`define CP_LINE_LENGTH_SEL_2 2
`define CP_REMOTE_LOOPBACK 3
`define CP_LOCAL_LOOPBACK 4
`define CP_TX_ALL_ONES 5
`endif

// File: lit_pkg.sv
// Types for the transmit and mode control block
package lit_pkg;
	typedef enum logic [1:0] {
		MODE_HW = 2'b00,
		MODE_EXT = 2'b01,
		MODE_HOST = 2'b10
	} op_mode_t;

	typedef struct packed {
		logic tx_all_ones;
		logic local_loopback;
		logic remote_loopback;
		logic [2:0] line_length;
	} ctrl_t;

	typedef struct packed {
		logic [12:0] sync1;
		logic [12:0] sync2;
		logic tx_clock_prev;
		op_mode_t mode;
		ctrl_t ctrl;
		logic [8:0] idle_cnt;
		logic clk_lost;
		logic [7:0] pulse_cnt;
		logic pulse_a;
		logic pulse_b;
		logic ami_phase;
		logic [7:0] settle_cnt;
		logic idle;
		logic [2:0] dsx_range;
		logic rx_pos_pin;
		logic rx_neg_pin;
		logic monitor_pin;
		logic rx_code_sel;
		logic pcs_n;
		logic tx_code_sel;
		logic [5:0] cp_out;
		logic [5:0] cp_oe;
		logic ser_in;
		logic ser_cs_n;
		logic ser_clk;
		logic clk_edge;
	} state_t;
endpackage

// File: line_interface_tx_mode_control.sv
// Mode decode, shared pin routing and transmit pulse control for the line interface
//
// Overview of operation
// RULE_01: Decode three-level mode input into hardware, extended hardware or host mode.
// RULE_02: Hardware and extended modes take controls and give status on discrete pins.
// RULE_03: Thirteen shared pins change function with the operating mode.
// RULE_04: Extended mode routes single-rail data, code selects, violation, alarm, chip select.
// RULE_05: Host mode turns control pins into interrupt and serial port pins.
// RULE_06: Transmit data, dual or single rail, is captured on falling transmit clock.
// RULE_07: Line-length codes 011 to 111 select five DSX-1 cable ranges.
// RULE_08: Code 000 selects PCM-30 shape, 001 reserved, 010 Part 68 shape.
// RULE_09: Pulse width follows line length: 324 ns Part 68, 350 ns DSX-1. Part 68 truncates to 32 reference cycles, 320 ns.
// RULE_10: On transmit clock loss neither line output stays driven high.
// RULE_11: Both data inputs low with clock running gives idle driver, no pulses.
// RULE_12: Control changes mark outputs unsettled 22 bits; remote loopback longer.
// RULE_13: All-ones sends continuous marks, ignores data, ignored during remote loopback.
// RULE_14: Decoded mode is static; routing switches only on mode input change.
`timescale 1ns/1ps
`include "lit_consts.svh"

module line_interface_tx_mode_control #(
	parameter logic [7:0] REMOTE_LOOPBACK_SETTLE = `REMOTE_LOOPBACK_SETTLE_BITS
) (
	input wire logic REF_CLK_IN,
	input wire logic RST_IN,
	input wire logic MODE_LOW_IN,
	input wire logic MODE_HIGH_IN,
	input wire logic TX_CLOCK_IN,
	input wire logic TX_POS_RAIL_IN,
	input wire logic TX_NEG_RAIL_IN,
	input wire logic MONITOR_IN_A_IN,
	input wire logic MONITOR_IN_B_IN,
	input wire logic [5:0] CTRL_PIN_IN,
	input wire logic RX_POS_RAIL_IN,
	input wire logic RX_NEG_RAIL_IN,
	input wire logic RX_DATA_IN,
	input wire logic BIPOLAR_VIOLATION_FLAG_IN,
	input wire logic DRIVER_MONITOR_FLAG_IN,
	input wire logic ALL_ONES_ALARM_IN,
	input wire logic SERIAL_OUT_IN,
	input wire logic HOST_INT_N_IN,
	input wire lit_pkg::ctrl_t HOST_CTRL_IN,
	output logic LINE_OUT_A_OUT,
	output logic LINE_OUT_B_OUT,
	output logic RX_POS_PIN_OUT,
	output logic RX_NEG_PIN_OUT,
	output logic MONITOR_PIN_OUT,
	output logic [5:0] CTRL_PIN_OUT,
	output logic [5:0] CTRL_PIN_OE_OUT,
	output logic RX_CODE_SELECT_OUT,
	output logic PARALLEL_CHIP_SELECT_N_OUT,
	output logic TX_CODE_SELECT_OUT,
	output logic SERIAL_IN_OUT,
	output logic SERIAL_CS_N_OUT,
	output logic SERIAL_CLK_OUT,
	output logic CLOCK_EDGE_SELECT_OUT,
	output lit_pkg::op_mode_t OP_MODE_OUT,
	output lit_pkg::ctrl_t ACTIVE_CTRL_OUT,
	output logic [2:0] DSX_RANGE_OUT,
	output logic TX_CLOCK_LOST_OUT,
	output logic TX_SETTLING_OUT,
	output logic DRIVER_IDLE_OUT
);
	lit_pkg::state_t st_ff;
	lit_pkg::state_t nxt_st;

	// Pin inputs gathered for the synchroniser
	logic [`PIN_W-1:0] pins;
	assign pins = {MODE_LOW_IN, MODE_HIGH_IN, TX_CLOCK_IN, TX_POS_RAIL_IN, TX_NEG_RAIL_IN,
		MONITOR_IN_A_IN, MONITOR_IN_B_IN, CTRL_PIN_IN};

	// ****************************************
	// Next state
	// ****************************************
	// Decode, route and transmit logic
	always_comb begin
		lit_pkg::op_mode_t dec_mode;
		lit_pkg::ctrl_t ctl;
		logic [`PIN_W-1:0] s;
		logic fall;
		logic mark;
		logic send_a;
		logic send_b;
		logic [7:0] width;
		dec_mode = lit_pkg::MODE_EXT;
		ctl = '0;
		s = st_ff.sync2;
		fall = 1'b0;
		mark = 1'b0;
		send_a = 1'b0;
		send_b = 1'b0;
		width = 8'h00;
		nxt_st = st_ff;

		// Two-stage synchroniser; only stage two is read
		nxt_st.sync1 = pins;
		nxt_st.sync2 = st_ff.sync1;
		nxt_st.tx_clock_prev = s[`PIN_TX_CLOCK];
		fall = st_ff.tx_clock_prev & ~s[`PIN_TX_CLOCK];

		// Three-level mode decode, latched only when the level changes
		if (s[`PIN_MODE_LOW]) begin
			dec_mode = lit_pkg::MODE_HW; // [RULE_01]
		end else if (s[`PIN_MODE_HIGH]) begin
			dec_mode = lit_pkg::MODE_HOST; // [RULE_01]
		end
		if (dec_mode != st_ff.mode) begin
			nxt_st.mode = dec_mode; // [RULE_14]
		end

		// Control source: discrete pins or host serial registers
		if (st_ff.mode == lit_pkg::MODE_HOST) begin
			ctl = HOST_CTRL_IN; // [RULE_05]
		end else begin
			ctl.line_length = s[`CP_LINE_LENGTH_SEL_2:`CP_LINE_LENGTH_SEL_0]; // [RULE_02]
			ctl.remote_loopback = s[`CP_REMOTE_LOOPBACK];
			ctl.local_loopback = s[`CP_LOCAL_LOOPBACK];
			ctl.tx_all_ones = s[`CP_TX_ALL_ONES];
		end
		nxt_st.ctrl = ctl;

		// Shared pin routing per mode
		nxt_st.rx_pos_pin = RX_POS_RAIL_IN; // [RULE_03]
		nxt_st.rx_neg_pin = RX_NEG_RAIL_IN;
		nxt_st.monitor_pin = DRIVER_MONITOR_FLAG_IN;
		nxt_st.rx_code_sel = 1'b0;
		nxt_st.pcs_n = 1'b1;
		nxt_st.tx_code_sel = 1'b0;
		nxt_st.cp_out = 6'h00;
		nxt_st.cp_oe = 6'h00;
		nxt_st.ser_in = 1'b0;
		nxt_st.ser_cs_n = 1'b1;
		nxt_st.ser_clk = 1'b0;
		nxt_st.clk_edge = 1'b0;
		case (st_ff.mode)
			lit_pkg::MODE_EXT: begin
				nxt_st.rx_pos_pin = RX_DATA_IN; // [RULE_04]
				nxt_st.rx_neg_pin = BIPOLAR_VIOLATION_FLAG_IN; // [RULE_04]
				nxt_st.monitor_pin = ALL_ONES_ALARM_IN; // [RULE_04]
				nxt_st.rx_code_sel = s[`PIN_MON_A]; // [RULE_04]
				nxt_st.pcs_n = s[`PIN_MON_B]; // [RULE_04]
				nxt_st.tx_code_sel = s[`PIN_TX_NEG_RAIL]; // [RULE_04]
			end
			lit_pkg::MODE_HOST: begin
				// Pin 23 interrupt, pin 25 serial data out tristated when deselected
				nxt_st.cp_out = {5'h00, HOST_INT_N_IN} | {3'h0, SERIAL_OUT_IN, 2'h0}; // [RULE_05]
				nxt_st.cp_oe = {3'h0, ~s[`CP_REMOTE_LOOPBACK], 1'b0, 1'b1}; // [RULE_05]
				nxt_st.ser_in = s[1];
				nxt_st.ser_cs_n = s[`CP_REMOTE_LOOPBACK];
				nxt_st.ser_clk = s[`CP_LOCAL_LOOPBACK];
				nxt_st.clk_edge = s[`CP_TX_ALL_ONES];
			end
			default: begin
			end
		endcase

		// Pulse shape and width from line length
		case (ctl.line_length)
			`LEN_PCM30: width = `PW_PCM30_CYC; // [RULE_08]
			`LEN_RESERVED: width = 8'h00; // [RULE_08]
			`LEN_PART68: width = `PW_PART68_CYC; // [RULE_08] [RULE_09]
			default: width = `PW_DSX1_CYC; // [RULE_09]
		endcase
		if (ctl.line_length >= `LEN_DSX_FIRST) begin
			nxt_st.dsx_range = ctl.line_length - `LEN_DSX_FIRST; // [RULE_07]
		end else begin
			nxt_st.dsx_range = 3'h0;
		end

		// Transmit clock watchdog
		if (fall) begin
			nxt_st.idle_cnt = 9'h000;
			nxt_st.clk_lost = 1'b0;
		end else if (st_ff.idle_cnt >= `TX_LOSS_CYC) begin
			nxt_st.clk_lost = 1'b1; // [RULE_10]
		end else begin
			nxt_st.idle_cnt = st_ff.idle_cnt + 9'h001;
		end

		// Running pulse counts down every cycle, marks or not
		if (st_ff.pulse_cnt > 8'h01) begin
			nxt_st.pulse_cnt = st_ff.pulse_cnt - 8'h01;
		end else begin
			nxt_st.pulse_cnt = 8'h00;
			nxt_st.pulse_a = 1'b0;
			nxt_st.pulse_b = 1'b0;
		end

		// Sample data on the falling transmit clock edge
		if (fall) begin
			if (ctl.tx_all_ones && !ctl.remote_loopback) begin
				mark = 1'b1; // [RULE_13]
			end else if (st_ff.mode == lit_pkg::MODE_EXT) begin
				mark = s[`PIN_TX_POS_RAIL]; // [RULE_06]
			end else begin
				send_a = s[`PIN_TX_POS_RAIL]; // [RULE_06]
				send_b = s[`PIN_TX_NEG_RAIL] & ~s[`PIN_TX_POS_RAIL];
			end
			if (mark) begin
				// Single rail and all-ones alternate polarity
				send_a = ~st_ff.ami_phase;
				send_b = st_ff.ami_phase;
				nxt_st.ami_phase = ~st_ff.ami_phase;
			end
			nxt_st.idle = ~(send_a | send_b); // [RULE_11]
			if ((send_a || send_b) && width != 8'h00) begin
				nxt_st.pulse_cnt = width;
				nxt_st.pulse_a = send_a;
				nxt_st.pulse_b = send_b;
			end
		end
		if (st_ff.clk_lost) begin
			nxt_st.pulse_cnt = 8'h00; // [RULE_10]
			nxt_st.pulse_a = 1'b0;
			nxt_st.pulse_b = 1'b0;
		end

		// Settling window after control changes, counted in bit periods
		if (ctl.remote_loopback != st_ff.ctrl.remote_loopback) begin
			nxt_st.settle_cnt = REMOTE_LOOPBACK_SETTLE; // [RULE_12]
		end else if (ctl.tx_all_ones != st_ff.ctrl.tx_all_ones ||
			ctl.line_length != st_ff.ctrl.line_length ||
			ctl.local_loopback != st_ff.ctrl.local_loopback) begin
			nxt_st.settle_cnt = `SETTLE_BITS; // [RULE_12]
		end else if (fall && st_ff.settle_cnt != 8'h00) begin
			nxt_st.settle_cnt = st_ff.settle_cnt - 8'h01;
		end
	end

	// ****************************************
	// State register
	// ****************************************
	// Synchronous reset to quiet driver, hardware mode
	always_ff @(posedge REF_CLK_IN) begin
		if (RST_IN) begin
			st_ff <= '0;
			st_ff.pcs_n <= 1'b1;
			st_ff.ser_cs_n <= 1'b1;
			st_ff.idle <= 1'b1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	// All outputs straight from the state register, except the settling flag, which is decoded from its count
	assign LINE_OUT_A_OUT = st_ff.pulse_a;
	assign LINE_OUT_B_OUT = st_ff.pulse_b;
	assign RX_POS_PIN_OUT = st_ff.rx_pos_pin;
	assign RX_NEG_PIN_OUT = st_ff.rx_neg_pin;
	assign MONITOR_PIN_OUT = st_ff.monitor_pin;
	assign CTRL_PIN_OUT = st_ff.cp_out;
	assign CTRL_PIN_OE_OUT = st_ff.cp_oe;
	assign RX_CODE_SELECT_OUT = st_ff.rx_code_sel;
	assign PARALLEL_CHIP_SELECT_N_OUT = st_ff.pcs_n;
	assign TX_CODE_SELECT_OUT = st_ff.tx_code_sel;
	assign SERIAL_IN_OUT = st_ff.ser_in;
	assign SERIAL_CS_N_OUT = st_ff.ser_cs_n;
	assign SERIAL_CLK_OUT = st_ff.ser_clk;
	assign CLOCK_EDGE_SELECT_OUT = st_ff.clk_edge;
	assign OP_MODE_OUT = st_ff.mode;
	assign ACTIVE_CTRL_OUT = st_ff.ctrl;
	assign DSX_RANGE_OUT = st_ff.dsx_range;
	assign TX_CLOCK_LOST_OUT = st_ff.clk_lost;
	assign TX_SETTLING_OUT = (st_ff.settle_cnt != 8'h00);
	assign DRIVER_IDLE_OUT = st_ff.idle;
endmodule

// File: lit_monitor.sv
// Checker for the transmit and mode control block
`timescale 1ns/1ps
module lit_monitor (
	input wire logic REF_CLK_IN,
	input wire logic RST_IN,
	input wire logic MODE_LOW_IN,
	input wire logic MODE_HIGH_IN,
	input wire logic [5:0] CTRL_PIN_IN,
	input wire logic LINE_OUT_A_OUT,
	input wire logic LINE_OUT_B_OUT,
	input wire logic [5:0] CTRL_PIN_OE_OUT,
	input wire logic PARALLEL_CHIP_SELECT_N_OUT,
	input wire logic SERIAL_CS_N_OUT,
	input wire lit_pkg::op_mode_t OP_MODE_OUT,
	input wire logic TX_CLOCK_LOST_OUT,
	input wire logic TX_SETTLING_OUT
);
	logic [3:0] up_ff;
	default clocking @(posedge REF_CLK_IN); endclocking
	default disable iff (RST_IN);
	// Cycles since reset, saturating
	always_ff @(posedge REF_CLK_IN) begin
		up_ff <= RST_IN ? 4'h0 : up_ff + 4'(up_ff != 4'hf);
	end
	sequence pins_quiet;
		$stable({MODE_LOW_IN, MODE_HIGH_IN})[*5] ##0 up_ff == 4'hf;
	endsequence
	sequence len_change;
		up_ff == 4'hf && OP_MODE_OUT == 2'h0 && $changed(CTRL_PIN_IN[2:0]);
	endsequence
	a_mode_legal: assert property (OP_MODE_OUT != 2'h3)
		else $error("Undefined mode");
	a_mode_static: assert property (pins_quiet |-> $stable(OP_MODE_OUT))
		else $error("Mode moved with quiet pins");
	a_host_oe_off: assert property (OP_MODE_OUT != 2'h2 && $past(OP_MODE_OUT) != 2'h2 |-> CTRL_PIN_OE_OUT == 6'h00)
		else $error("Shared pin driven outside host mode");
	a_pcs_idle: assert property (OP_MODE_OUT != 2'h1 && $past(OP_MODE_OUT) != 2'h1 |-> PARALLEL_CHIP_SELECT_N_OUT)
		else $error("Chip select active outside extended mode");
	a_serial_cs_idle: assert property (OP_MODE_OUT != 2'h2 && $past(OP_MODE_OUT) != 2'h2 |-> SERIAL_CS_N_OUT)
		else $error("Serial select active outside host mode");
	a_lost_quiet: assert property (TX_CLOCK_LOST_OUT && $past(TX_CLOCK_LOST_OUT) |-> !LINE_OUT_A_OUT && !LINE_OUT_B_OUT)
		else $error("Line driven with clock lost");
	a_pulse_min: assert property ($rose(LINE_OUT_A_OUT) |-> LINE_OUT_A_OUT[*8])
		else $error("Line pulse too short");
	a_settle_start: assert property (len_change |-> ##[2:6] TX_SETTLING_OUT)
		else $error("No settling after control change");
endmodule
bind line_interface_tx_mode_control lit_monitor i_mon (.REF_CLK_IN(REF_CLK_IN), .RST_IN(RST_IN),
	.MODE_LOW_IN(MODE_LOW_IN), .MODE_HIGH_IN(MODE_HIGH_IN), .CTRL_PIN_IN(CTRL_PIN_IN),
	.LINE_OUT_A_OUT(LINE_OUT_A_OUT), .LINE_OUT_B_OUT(LINE_OUT_B_OUT), .CTRL_PIN_OE_OUT(CTRL_PIN_OE_OUT),
	.PARALLEL_CHIP_SELECT_N_OUT(PARALLEL_CHIP_SELECT_N_OUT), .SERIAL_CS_N_OUT(SERIAL_CS_N_OUT),
	.OP_MODE_OUT(OP_MODE_OUT), .TX_CLOCK_LOST_OUT(TX_CLOCK_LOST_OUT), .TX_SETTLING_OUT(TX_SETTLING_OUT));

// File: tx_framer_model.sv
// Framer model: transmit clock and dual-rail data
`timescale 1ns/1ps
module tx_framer_model (
	input wire logic run_in,
	input wire logic [1:0] data_in,
	output logic clk_out,
	output logic [1:0] rail_out
);
	initial clk_out = 1'b0;
	initial rail_out = 2'h0;
	// Rails change on the rising half
	// Clock stands low when stopped, rails then toggle
	always #40 begin
		clk_out = run_in & ~clk_out;
		if (clk_out) begin
			rail_out = data_in;
		end else if (!run_in) begin
			rail_out = ~rail_out;
		end
	end
endmodule

// File: line_interface_tx_mode_control_tb.sv
// Self-checking bench for the transmit and mode control block
`timescale 1ns/1ps
module line_interface_tx_mode_control_tb;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [1:0] mpin = 2'h2;
	logic [5:0] cpin = 6'h00;
	logic [7:0] src = 8'h01;
	logic run = 1'b1;
	logic [1:0] dat = 2'h0;
	logic tx_clock, a, b, rxp, pcs_n, scs_n, lost, setl, idle;
	logic [1:0] rail;
	logic [5:0] cpoe;
	logic [2:0] dsx;
	lit_pkg::op_mode_t mode;
	int errors = 0;
	int total_checks = 0;
	// Rows: mode pins, control pins, mode, range
	logic [12:0] rows [5] = '{13'h1060, 13'h10e4, 13'h00aa, 13'h0813, 13'h1000};
	line_interface_tx_mode_control #(.REMOTE_LOOPBACK_SETTLE(8'h1e)) i_dut (.REF_CLK_IN(clk), .RST_IN(rst),
		.MODE_LOW_IN(mpin[1]), .MODE_HIGH_IN(mpin[0]), .TX_CLOCK_IN(tx_clock), .TX_POS_RAIL_IN(rail[0]),
		.TX_NEG_RAIL_IN(rail[1]), .MONITOR_IN_A_IN(src[7]), .MONITOR_IN_B_IN(src[6]), .CTRL_PIN_IN(cpin),
		.RX_POS_RAIL_IN(src[0]), .RX_NEG_RAIL_IN(src[1]), .RX_DATA_IN(src[2]),
		.BIPOLAR_VIOLATION_FLAG_IN(src[3]), .DRIVER_MONITOR_FLAG_IN(src[4]), .ALL_ONES_ALARM_IN(src[5]),
		.SERIAL_OUT_IN(src[6]), .HOST_INT_N_IN(src[7]), .HOST_CTRL_IN(6'h06), .LINE_OUT_A_OUT(a),
		.LINE_OUT_B_OUT(b), .RX_POS_PIN_OUT(rxp), .RX_NEG_PIN_OUT(), .MONITOR_PIN_OUT(), .CTRL_PIN_OUT(),
		.CTRL_PIN_OE_OUT(cpoe), .RX_CODE_SELECT_OUT(), .PARALLEL_CHIP_SELECT_N_OUT(pcs_n),
		.TX_CODE_SELECT_OUT(), .SERIAL_IN_OUT(), .SERIAL_CS_N_OUT(scs_n), .SERIAL_CLK_OUT(),
		.CLOCK_EDGE_SELECT_OUT(), .OP_MODE_OUT(mode), .ACTIVE_CTRL_OUT(), .DSX_RANGE_OUT(dsx),
		.TX_CLOCK_LOST_OUT(lost), .TX_SETTLING_OUT(setl), .DRIVER_IDLE_OUT(idle));
	tx_framer_model i_far (.run_in(run), .data_in(dat), .clk_out(tx_clock), .rail_out(rail));
	// Reference clock
	always #5 clk = ~clk;
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("BAD %s exp %h got %h", what, exp, got);
		end
	endtask
	task automatic test_done;
		if (errors == 0 && total_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// One mark on the given rails, then count the pulse on A (pos) or B (neg only)
	task automatic pw(input logic [2:0] len, input logic [1:0] d, input logic [7:0] exp);
		int n;
		n = 0;
		@(posedge clk) cpin <= {3'h0, len};
		cyc(20);
		@(posedge tx_clock);
		@(posedge clk) dat <= d;
		@(posedge tx_clock);
		@(posedge clk) dat <= 2'h0;
		repeat (60) @(posedge clk) n += int'(d[0] ? a : b);
		chk("width", 8'(n), exp);
	endtask
	// Main sequence
	initial begin
		int i;
		logic [1:0] seen;
		repeat (4) @(posedge clk);
		@(posedge clk) rst <= 1'b0;
		#1;
		chk("reset", 8'({mode, pcs_n, scs_n, idle, a}), 8'h0e);
		for (i = 0; i < 5; i++) begin
			@(posedge clk);
			mpin <= rows[i][12:11];
			cpin <= rows[i][10:5];
			cyc(10);
			chk("mode", 8'(mode), 8'(rows[i][4:3]));
			chk("range", 8'(dsx), 8'(rows[i][2:0]));
			chk("oe", 8'(cpoe), rows[i][4:3] == 2'h2 ? 8'h05 : 8'h00);
			chk("pcs", 8'(pcs_n), 8'(rows[i][4:3] != 2'h1));
			chk("rxp", 8'(rxp), 8'(rows[i][4:3] != 2'h1));
		end
		pw(3'h0, 2'h1, 8'h18);
		pw(3'h2, 2'h1, 8'h20);
		pw(3'h7, 2'h1, 8'h23);
		pw(3'h7, 2'h2, 8'h23);
		pw(3'h7, 2'h3, 8'h23);
		pw(3'h1, 2'h1, 8'h00);
		chk("idle", 8'(idle), 8'h01);
		// All-ones with data held low, then under remote loopback
		@(posedge clk) cpin <= 6'h23;
		cyc(10);
		seen = 2'h0;
		repeat (64) @(posedge clk) seen |= {b, a};
		chk("ones", 8'(seen), 8'h03);
		cyc(80);
		chk("settle", 8'(setl), 8'h01);
		cyc(70);
		chk("settle", 8'(setl), 8'h00);
		@(posedge clk) cpin <= 6'h2b;
		cyc(100);
		seen = 2'h0;
		repeat (64) @(posedge clk) seen |= {b, a};
		chk("ones_rl", 8'(seen), 8'h00);
		cyc(40);
		chk("settle_rl", 8'(setl), 8'h01);
		// Stopped transmit clock
		@(posedge clk) run <= 1'b0;
		cyc(220);
		chk("lost", 8'({lost, a, b}), 8'h04);
		@(posedge clk) run <= 1'b1;
		cyc(40);
		chk("lost", 8'(lost), 8'h00);
		// Reset in mid-run
		@(posedge clk) rst <= 1'b1;
		cyc(3);
		chk("rerst", 8'({mode, idle, scs_n}), 8'h03);
		@(posedge clk) rst <= 1'b0;
		cyc(10);
		chk("rerst_mode", 8'({mode, pcs_n, lost}), 8'h02);
		test_done;
	end
	// Hang guard
	initial begin
		#200000;
		errors++;
		test_done;
	end
endmodule
